// ### include/flash_seq_consts.vh
// constants for the program and erase command sequencer of the serial flash
// assumes it is included by bare name from every design file that needs it
//
// Notes on behaviour
// - opcode 83H programs buffer one, 86H buffer two, each with built-in erase
// - with built-in erase the page is erased to ones first, then programmed
// - opcode 88H programs buffer one, 89H buffer two, same three-byte page address
// - program without erase writes the page at chip-select rise, no erase
// - page erase is opcode 81H followed by three address bytes
// - 264-byte mode: 3 leading don't-care bits, 12-bit page, 9 trailing bits
// - 256-byte mode: 4 leading don't-care bits, page in bits 19..8, 8 trailing
// - every erase leaves the affected cells at logic one
// - block erase is opcode 50H, eight pages, index from upper nine page bits
// - 264-byte mode block index is page bits 11..3, blocks 0 to 511
// - 256-byte mode block index is address bits 19..11
// - at chip-select rise after block erase all eight pages are erased
// - sector erase is opcode 7CH; sixteen sectors, one erased per request
// - 264-byte mode: sectors 1-15 from page bits 11..8; 0a/0b by page bits 7..3
// - 256-byte mode: sectors 1-15 from address bits 19..16
// - 256-byte mode: sectors 0a/0b chosen through address bits 19..11
// - any page inside the sector selects and erases the whole sector
// - operations start at chip-select rise, run self-timed, busy throughout
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH

// opcodes
`define OP_PROG_ERASE_BUF1 8'h83
`define OP_PROG_ERASE_BUF2 8'h86
`define OP_PROG_ONLY_BUF1 8'h88
`define OP_PROG_ONLY_BUF2 8'h89
`define OP_PAGE_ERASE 8'h81
`define OP_BLOCK_ERASE 8'h50
`define OP_SECTOR_ERASE 8'h7C

// frame layout
`define FRAME_BYTES 3'h4
`define FRAME_BITS_LAST 5'h1F
`define OPCODE_MSB 31
`define OPCODE_LSB 24
`define ADDR_MSB 23
`define ADDR_LSB 0

// page number position in the address bytes per page-size mode
`define PAGE264_MSB 20
`define PAGE264_LSB 9
`define PAGE256_MSB 19
`define PAGE256_LSB 8

// fields of the 12-bit page number
`define BLOCK_MSB 11
`define BLOCK_LSB 3
`define SECTOR_MSB 11
`define SECTOR_LSB 8
`define SUB0_MSB 7
`define SUB0_LSB 3

// erase extents, in pages
`define PAGES_ONE 9'h001
`define PAGES_BLOCK 9'h008
`define PAGES_SECTOR 9'h100
`define PAGES_SECTOR_0A 9'h008
`define PAGES_SECTOR_0B 9'h0F8
`define FIRST_SECTOR_0B 12'h008
`define SECTOR_ZERO 4'h0
`define SUB0_ZERO 5'h00
`define BLOCK_PAD 3'h0
`define SECTOR_PAD 8'h00

// erased cell value
`define ERASED_BYTE 8'hFF

// clock
`define CLK_PERIOD_NS 8

`endif

// ### rtl/flash_program_erase.v
// command decode and sequencing of page program and erase operations
// assumes the array side acts on the start pulses and the host polls BUSY
`timescale 1ns/1ps
`include "flash_seq_consts.vh"
module flash_program_erase #(
    parameter PAGE_ERASE_TIME_NS = 32'd40000,    // page_erase_time
    parameter PROGRAM_ONLY_TIME_NS = 32'd40000,  // program_only_time
    parameter BLOCK_ERASE_TIME_NS = 32'd80000,   // block_erase_time
    parameter SECTOR_ERASE_TIME_NS = 32'd160000, // sector_erase_time
    parameter TIMER_WIDTH = 32
) (
    input wire CLK,                    // system clock, 125 MHz
    input wire RESET_N,                // asynchronous reset, active low
    input wire SCK,                    // serial clock pin
    input wire CS_N,                   // chip select pin, active low
    input wire SI,                     // serial input pin
    input wire PAGE_MODE_256,          // high selects 256-byte pages
    output reg BUSY,                   // status busy indication
    output reg ERASE_START,            // pulse: erase pages now
    output reg [11:0] ERASE_FIRST_PAGE, // first page to erase
    output reg [8:0] ERASE_PAGE_COUNT, // pages to erase
    output reg [7:0] ERASE_FILL,       // value written to erased cells
    output reg PROGRAM_START,          // pulse: program page from buffer
    output reg [11:0] PROGRAM_PAGE,    // page to program
    output reg PROGRAM_BUFFER          // low buffer one, high buffer two
);

// ----------------------------------------------------------------
// phase lengths in cycles
// ----------------------------------------------------------------
localparam [TIMER_WIDTH-1:0] PAGE_ERASE_CYCLES =
    (PAGE_ERASE_TIME_NS / `CLK_PERIOD_NS) < 1 ? 1 : PAGE_ERASE_TIME_NS / `CLK_PERIOD_NS;
localparam [TIMER_WIDTH-1:0] PROGRAM_ONLY_CYCLES =
    (PROGRAM_ONLY_TIME_NS / `CLK_PERIOD_NS) < 1 ? 1 : PROGRAM_ONLY_TIME_NS / `CLK_PERIOD_NS;
localparam [TIMER_WIDTH-1:0] BLOCK_ERASE_CYCLES =
    (BLOCK_ERASE_TIME_NS / `CLK_PERIOD_NS) < 1 ? 1 : BLOCK_ERASE_TIME_NS / `CLK_PERIOD_NS;
localparam [TIMER_WIDTH-1:0] SECTOR_ERASE_CYCLES =
    (SECTOR_ERASE_TIME_NS / `CLK_PERIOD_NS) < 1 ? 1 : SECTOR_ERASE_TIME_NS / `CLK_PERIOD_NS;

// ----------------------------------------------------------------
// sequencer states
// ----------------------------------------------------------------
localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_ERASE = 2'h1;
localparam [1:0] ST_PROGRAM = 2'h2;
reg [1:0] state; // current sequencer state, read by the acceptance logic below

// ----------------------------------------------------------------
// frame reception
// ----------------------------------------------------------------
wire frame_end;
wire frame_full;
wire [31:0] frame;

frame_rx u_rx (
    .clk(CLK),
    .reset_n(RESET_N),
    .sck_pin(SCK),
    .cs_n_pin(CS_N),
    .si_pin(SI),
    .frame_end(frame_end),
    .frame_full(frame_full),
    .frame(frame)
);

// ----------------------------------------------------------------
// page-size mode pin synchroniser
// ----------------------------------------------------------------
reg [1:0] mode_sync;

// two flops before the decoder reads the mode
always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
        mode_sync <= 2'h0;
    end else begin
        mode_sync <= {mode_sync[0], PAGE_MODE_256};
    end
end

wire mode_256 = mode_sync[1];

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
wire [7:0] opcode = frame[`OPCODE_MSB:`OPCODE_LSB];
wire [23:0] addr = frame[`ADDR_MSB:`ADDR_LSB];

// page number from the address bytes in either layout
wire [11:0] page = mode_256 ? addr[`PAGE256_MSB:`PAGE256_LSB] :
                              addr[`PAGE264_MSB:`PAGE264_LSB];
wire [8:0] block_index = page[`BLOCK_MSB:`BLOCK_LSB];
wire [3:0] sector_index = page[`SECTOR_MSB:`SECTOR_LSB];
wire [4:0] sub0_bits = page[`SUB0_MSB:`SUB0_LSB];

reg [11:0] sector_first;
reg [8:0] sector_count;

// any page inside a sector maps to the whole sector
always @* begin
    sector_first = {sector_index, `SECTOR_PAD};
    sector_count = `PAGES_SECTOR;
    if (sector_index == `SECTOR_ZERO) begin
        if (sub0_bits == `SUB0_ZERO) begin
            sector_first = {`SECTOR_ZERO, `SECTOR_PAD};
            sector_count = `PAGES_SECTOR_0A;
        end else begin
            sector_first = `FIRST_SECTOR_0B;
            sector_count = `PAGES_SECTOR_0B;
        end
    end
end

// ----------------------------------------------------------------
// command decode
// ----------------------------------------------------------------
reg cmd_valid;
reg cmd_erase;
reg cmd_program;
reg cmd_buffer;
reg [11:0] cmd_first;
reg [8:0] cmd_count;
reg [TIMER_WIDTH-1:0] cmd_erase_cycles;

// classify the opcode and work out the erase extent
always @* begin
    cmd_valid = 1'b1;
    cmd_erase = 1'b0;
    cmd_program = 1'b0;
    cmd_buffer = 1'b0;
    cmd_first = page;
    cmd_count = `PAGES_ONE;
    cmd_erase_cycles = PAGE_ERASE_CYCLES;
    case (opcode)
        `OP_PROG_ERASE_BUF1: begin
            cmd_erase = 1'b1;
            cmd_program = 1'b1;
        end
        `OP_PROG_ERASE_BUF2: begin
            cmd_erase = 1'b1;
            cmd_program = 1'b1;
            cmd_buffer = 1'b1;
        end
        `OP_PROG_ONLY_BUF1: begin
            cmd_program = 1'b1;
        end
        `OP_PROG_ONLY_BUF2: begin
            cmd_program = 1'b1;
            cmd_buffer = 1'b1;
        end
        `OP_PAGE_ERASE: begin
            cmd_erase = 1'b1;
        end
        `OP_BLOCK_ERASE: begin
            cmd_erase = 1'b1;
            cmd_first = {block_index, `BLOCK_PAD};
            cmd_count = `PAGES_BLOCK;
            cmd_erase_cycles = BLOCK_ERASE_CYCLES;
        end
        `OP_SECTOR_ERASE: begin
            cmd_erase = 1'b1;
            cmd_first = sector_first;
            cmd_count = sector_count;
            cmd_erase_cycles = SECTOR_ERASE_CYCLES;
        end
        default: begin
            cmd_valid = 1'b0;
        end
    endcase
end

// a command runs only from a complete frame while the sequencer is idle
wire accept = frame_end & frame_full & cmd_valid & (state == ST_IDLE);

// ----------------------------------------------------------------
// phase timer
// ----------------------------------------------------------------
reg timer_load;
reg [TIMER_WIDTH-1:0] timer_cycles;
wire timer_done;

op_timer #(
    .WIDTH(TIMER_WIDTH)
) u_timer (
    .clk(CLK),
    .reset_n(RESET_N),
    .load(timer_load),
    .cycles(timer_cycles),
    .done(timer_done)
);

// ----------------------------------------------------------------
// sequencer
// ----------------------------------------------------------------
reg [1:0] next_state;
reg pending_program;

// erase first where asked, then program, busy until the last phase ends
always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
        state <= ST_IDLE;
        pending_program <= 1'b0;
        timer_load <= 1'b0;
        timer_cycles <= {TIMER_WIDTH{1'b0}};
        BUSY <= 1'b0;
        ERASE_START <= 1'b0;
        ERASE_FIRST_PAGE <= 12'h000;
        ERASE_PAGE_COUNT <= 9'h000;
        ERASE_FILL <= `ERASED_BYTE;
        PROGRAM_START <= 1'b0;
        PROGRAM_PAGE <= 12'h000;
        PROGRAM_BUFFER <= 1'b0;
    end else begin
        state <= next_state;
        timer_load <= 1'b0;
        ERASE_START <= 1'b0;
        PROGRAM_START <= 1'b0;
        ERASE_FILL <= `ERASED_BYTE;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    BUSY <= 1'b1;
                    PROGRAM_PAGE <= page;
                    PROGRAM_BUFFER <= cmd_buffer;
                    timer_load <= 1'b1;
                    if (cmd_erase) begin
                        pending_program <= cmd_program;
                        ERASE_START <= 1'b1;
                        ERASE_FIRST_PAGE <= cmd_first;
                        ERASE_PAGE_COUNT <= cmd_count;
                        timer_cycles <= cmd_erase_cycles;
                    end else begin
                        pending_program <= 1'b0;
                        PROGRAM_START <= 1'b1;
                        timer_cycles <= PROGRAM_ONLY_CYCLES;
                    end
                end
            end
            ST_ERASE: begin
                if (timer_done) begin
                    if (pending_program) begin
                        pending_program <= 1'b0;
                        PROGRAM_START <= 1'b1;
                        timer_load <= 1'b1;
                        timer_cycles <= PROGRAM_ONLY_CYCLES;
                    end else begin
                        BUSY <= 1'b0;
                    end
                end
            end
            ST_PROGRAM: begin
                if (timer_done) begin
                    BUSY <= 1'b0;
                end
            end
            default: begin
                BUSY <= 1'b0;
            end
        endcase
    end
end

// next state of the sequencer
always @* begin
    next_state = state;
    case (state)
        ST_IDLE: begin
            if (accept) begin
                next_state = cmd_erase ? ST_ERASE : ST_PROGRAM;
            end
        end
        ST_ERASE: begin
            if (timer_done) begin
                next_state = pending_program ? ST_PROGRAM : ST_IDLE;
            end
        end
        ST_PROGRAM: begin
            if (timer_done) begin
                next_state = ST_IDLE;
            end
        end
        default: begin
            next_state = ST_IDLE;
        end
    endcase
end

endmodule

// ### rtl/frame_rx.v
// serial frame receiver: synchronises the pins, shifts in opcode and address
// assumes spi mode 0 or 3, data sampled on the rising serial clock edge
`timescale 1ns/1ps
`include "flash_seq_consts.vh"
module frame_rx (
    input wire clk,             // system clock
    input wire reset_n,         // asynchronous reset, active low
    input wire sck_pin,         // serial clock from the host
    input wire cs_n_pin,        // chip select from the host, active low
    input wire si_pin,          // serial data from the host
    output reg frame_end,       // one-cycle pulse on chip-select rise
    output reg frame_full,      // at least opcode and three address bytes seen
    output reg [31:0] frame     // opcode then three address bytes
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg [1:0] sck_sync;
reg [1:0] cs_sync;
reg [1:0] si_sync;
reg sck_last;
reg cs_last;

// two flops on each pin, then one more on the clock and chip-select pins for edge finding
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        sck_sync <= 2'h0;
        cs_sync <= 2'h3;
        si_sync <= 2'h0;
        sck_last <= 1'b0;
        cs_last <= 1'b1;
    end else begin
        sck_sync <= {sck_sync[0], sck_pin};
        cs_sync <= {cs_sync[0], cs_n_pin};
        si_sync <= {si_sync[0], si_pin};
        sck_last <= sck_sync[1];
        cs_last <= cs_sync[1];
    end
end

wire sck_rise = sck_sync[1] & ~sck_last;
wire selected = ~cs_sync[1];
wire cs_fall = ~cs_sync[1] & cs_last;
wire cs_rise = cs_sync[1] & ~cs_last;

// ----------------------------------------------------------------
// shifter
// ----------------------------------------------------------------
reg [4:0] bit_count;

// first 32 bits kept, later bits ignored; a new frame clears the count
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        bit_count <= 5'h00;
        frame_full <= 1'b0;
        frame <= 32'h00000000;
        frame_end <= 1'b0;
    end else begin
        frame_end <= cs_rise;
        if (cs_fall) begin
            bit_count <= 5'h00;
            frame_full <= 1'b0;
        end else if (selected && sck_rise && !frame_full) begin
            frame <= {frame[30:0], si_sync[1]};
            bit_count <= bit_count + 5'h01;
            if (bit_count == `FRAME_BITS_LAST) begin
                frame_full <= 1'b1;
            end
        end
    end
end

endmodule

// ### rtl/op_timer.v
// down counter timing one self-timed phase of an array operation
// assumes load is a one-cycle pulse from logic on the same clock
`timescale 1ns/1ps
module op_timer #(
    parameter WIDTH = 32
) (
    input wire clk,              // system clock
    input wire reset_n,          // asynchronous reset, active low
    input wire load,             // start a phase
    input wire [WIDTH-1:0] cycles, // phase length in cycles, at least one
    output reg done              // one-cycle pulse at the end of the phase
);

// ----------------------------------------------------------------
// counter
// ----------------------------------------------------------------
reg [WIDTH-1:0] count;
reg running;

// counts down to one, then flags the end of the phase
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        count <= {WIDTH{1'b0}};
        running <= 1'b0;
        done <= 1'b0;
    end else begin
        done <= 1'b0;
        if (load) begin
            count <= cycles;
            running <= 1'b1;
        end else if (running) begin
            if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                running <= 1'b0;
                done <= 1'b1;
            end else begin
                count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end
end

endmodule

// ### verif/flash_seq_monitor.sv
// assertions on the ports of the program and erase sequencer
// assumes every self-timed phase lasts at least eight clock cycles
`timescale 1ns/1ps
module flash_seq_monitor (
    input wire CLK, // system clock
    input wire RESET_N, // reset, active low
    input wire SCK, // serial clock pin
    input wire CS_N, // chip select pin
    input wire SI, // serial input pin
    input wire PAGE_MODE_256, // page size select
    input wire BUSY, // busy indication
    input wire ERASE_START, // erase pulse
    input wire [11:0] ERASE_FIRST_PAGE, // first erased page
    input wire [8:0] ERASE_PAGE_COUNT, // erased page count
    input wire [7:0] ERASE_FILL, // erased cell value
    input wire PROGRAM_START, // program pulse
    input wire [11:0] PROGRAM_PAGE, // programmed page
    input wire PROGRAM_BUFFER // source buffer
);
    // ----------------------------------------
    // checks on one clock domain
    // ----------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    fill_ones_a: assert property (ERASE_FILL == 8'hFF)
        else $error("erase fill is not all ones");
    start_pulse_a: assert property (ERASE_START |=> !ERASE_START)
        else $error("erase start longer than one cycle");
    busy_rise_a: assert property ($rose(BUSY) |-> ERASE_START || PROGRAM_START)
        else $error("busy rose without a start");
    start_busy_a: assert property (ERASE_START || PROGRAM_START |-> BUSY)
        else $error("start while not busy");
    cs_rise_a: assert property ($rose(BUSY) |-> CS_N && !$past(CS_N, 7))
        else $error("operation began without a frame end");
    erase_len_a: assert property (ERASE_START |=> BUSY [*8])
        else $error("busy dropped during erase");
    count_legal_a: assert property (ERASE_START |->
        ERASE_PAGE_COUNT inside {9'h001, 9'h008, 9'h0F8, 9'h100})
        else $error("illegal erase page count");
    block_align_a: assert property (ERASE_START && ERASE_PAGE_COUNT == 9'h008
        |-> ERASE_FIRST_PAGE[2:0] == 3'h0)
        else $error("eight page erase not aligned");
    sector_align_a: assert property (ERASE_START && ERASE_PAGE_COUNT == 9'h100
        |-> ERASE_FIRST_PAGE[7:0] == 8'h00 && ERASE_FIRST_PAGE[11:8] != 4'h0)
        else $error("sector erase not aligned");
    sector_zero_b_a: assert property (ERASE_START && ERASE_PAGE_COUNT == 9'h0F8
        |-> ERASE_FIRST_PAGE == 12'h008)
        else $error("second part of sector zero misplaced");
    erase_first_a: assert property (PROGRAM_START && !$rose(BUSY)
        |-> ERASE_PAGE_COUNT == 9'h001 && PROGRAM_PAGE == ERASE_FIRST_PAGE)
        else $error("program after erase hit another page");
endmodule
bind flash_program_erase flash_seq_monitor i_flash_seq_monitor (.CLK(CLK), .RESET_N(RESET_N),
    .SCK(SCK), .CS_N(CS_N), .SI(SI), .PAGE_MODE_256(PAGE_MODE_256), .BUSY(BUSY),
    .ERASE_START(ERASE_START), .ERASE_FIRST_PAGE(ERASE_FIRST_PAGE),
    .ERASE_PAGE_COUNT(ERASE_PAGE_COUNT), .ERASE_FILL(ERASE_FILL),
    .PROGRAM_START(PROGRAM_START), .PROGRAM_PAGE(PROGRAM_PAGE),
    .PROGRAM_BUFFER(PROGRAM_BUFFER));

// ### verif/spi_host_model.sv
// host serial master: sends one frame of opcode and address bits
// assumes the bench raises start while idle; serial clock half period is 4 clocks
`timescale 1ns/1ps
module spi_host_model (
    input wire clk, // system clock
    input wire start, // begin a frame
    input wire [31:0] frame, // opcode then address, msb first
    input wire [5:0] nbits, // bits clocked before chip select rises
    output reg sck, // serial clock, low outside frames
    output reg cs_n, // chip select, active low
    output reg si, // serial data
    output reg idle // no frame in progress
);
    reg [31:0] sh;
    reg [5:0] left;
    reg [1:0] cnt;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        idle = 1'b1;
    end
    // shift out on falling serial clock, device samples on rising
    always @(negedge clk) begin
        if (idle) begin
            if (start) begin
                idle <= 1'b0;
                cs_n <= 1'b0;
                sh <= frame;
                si <= frame[31];
                left <= nbits;
                cnt <= 2'h0;
            end else begin
                si <= ~si; // released line keeps changing
            end
        end else begin
            cnt <= cnt + 2'h1;
            if (cnt == 2'h3) begin
                if (left == 6'h00) begin
                    cs_n <= 1'b1;
                    idle <= 1'b1;
                end else if (!sck) begin
                    sck <= 1'b1;
                end else begin
                    sck <= 1'b0;
                    sh <= {sh[30:0], 1'b0};
                    si <= sh[30];
                    left <= left - 6'h01;
                end
            end
        end
    end
endmodule

// ### verif/tb.sv
// self-checking bench for the program and erase sequencer
// assumes the host model drives the pins and short phase times are set
`timescale 1ns/1ps
module tb;
    reg CLK = 1'b0;
    reg RESET_N = 1'b0;
    reg PAGE_MODE_256 = 1'b0;
    wire SCK, CS_N, SI, BUSY, ERASE_START, PROGRAM_START, PROGRAM_BUFFER, idle;
    wire [11:0] ERASE_FIRST_PAGE, PROGRAM_PAGE;
    wire [8:0] ERASE_PAGE_COUNT;
    wire [7:0] ERASE_FILL;
    reg start = 1'b0;
    reg [31:0] frame = 32'h0;
    reg [5:0] nbits = 6'h20;
    reg [31:0] seed = 32'd58806;
    reg [79:0] optab = 80'h81_88_81_89_83_86_50_7C_7C_7C;
    reg [22:0] notes [$];
    integer n_mismatch = 0;
    integer n_checks = 0;
    integer i, m, k;
    reg [7:0] op;
    reg [11:0] pg;
    always #4 CLK = ~CLK;
    flash_program_erase #(.PAGE_ERASE_TIME_NS(32'd80), .PROGRAM_ONLY_TIME_NS(32'd80),
        .BLOCK_ERASE_TIME_NS(32'd160), .SECTOR_ERASE_TIME_NS(32'd8000))
        i_flash_program_erase (.CLK(CLK), .RESET_N(RESET_N), .SCK(SCK), .CS_N(CS_N),
        .SI(SI), .PAGE_MODE_256(PAGE_MODE_256), .BUSY(BUSY), .ERASE_START(ERASE_START),
        .ERASE_FIRST_PAGE(ERASE_FIRST_PAGE), .ERASE_PAGE_COUNT(ERASE_PAGE_COUNT),
        .ERASE_FILL(ERASE_FILL), .PROGRAM_START(PROGRAM_START),
        .PROGRAM_PAGE(PROGRAM_PAGE), .PROGRAM_BUFFER(PROGRAM_BUFFER));
    spi_host_model i_spi_host_model (.clk(CLK), .start(start), .frame(frame),
        .nbits(nbits), .sck(SCK), .cs_n(CS_N), .si(SI), .idle(idle));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [31:0] xs(input [31:0] x);
        reg [31:0] y;
        begin
            y = x ^ (x << 13);
            y = y ^ (y >> 17);
            xs = y ^ (y << 5);
        end
    endfunction
    task check(input [22:0] seen, input [22:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // notes: kind, buffer, page count, page
    task expect_op(input [7:0] o, input [11:0] p);
        begin
            case (o)
                8'h83, 8'h86: begin
                    notes.push_back({2'b00, 9'h001, p});
                    notes.push_back({1'b1, o == 8'h86, 9'h000, p});
                end
                8'h88, 8'h89: notes.push_back({1'b1, o == 8'h89, 9'h000, p});
                8'h81: notes.push_back({2'b00, 9'h001, p});
                8'h50: notes.push_back({2'b00, 9'h008, p[11:3], 3'h0});
                8'h7C: begin
                    if (p[11:8] != 4'h0) notes.push_back({2'b00, 9'h100, p[11:8], 8'h00});
                    else if (p[7:3] == 5'h00) notes.push_back({2'b00, 9'h008, 12'h000});
                    else notes.push_back({2'b00, 9'h0F8, 12'h008});
                end
                default: ;
            endcase
        end
    endtask
    task send(input [7:0] o, input [11:0] p, input [5:0] nb);
        begin
            seed = xs(seed);
            if (PAGE_MODE_256) frame = {o, seed[3:0], p, seed[11:4]};
            else frame = {o, seed[2:0], p, seed[11:3]};
            // unknown-opcode frame ends in zero, so a short frame after it would decode
            if (o == 8'h84) frame[0] = 1'b0;
            nbits = nb;
            repeat (8) @(posedge CLK);
            start <= 1'b1;
            k = 0;
            while (idle === 1'b1 && k < 8) begin
                @(posedge CLK);
                k = k + 1;
            end
            start <= 1'b0;
            k = 0;
            while (idle !== 1'b1 && k < 400) begin
                @(posedge CLK);
                k = k + 1;
            end
        end
    endtask
    task wait_busy(input v, input integer lim);
        begin
            k = 0;
            while (BUSY !== v && k < lim) begin
                @(posedge CLK);
                k = k + 1;
            end
            check({22'h0, BUSY}, {22'h0, v});
        end
    endtask
    task run(input [7:0] o, input [11:0] p);
        begin
            expect_op(o, p);
            send(o, p, 6'h20);
            wait_busy(1'b1, 20);
            wait_busy(1'b0, 3000);
        end
    endtask
    // ----------------------------------------
    // result watcher: takes the oldest note at each start pulse
    // ----------------------------------------
    always @(posedge CLK) begin
        if (RESET_N === 1'b1 && ERASE_START === 1'b1) begin
            if (notes.size() == 0) check({2'b00, ERASE_PAGE_COUNT, ERASE_FIRST_PAGE}, 23'h7FFFFF);
            else check({2'b00, ERASE_PAGE_COUNT, ERASE_FIRST_PAGE}, notes.pop_front());
        end
        if (RESET_N === 1'b1 && PROGRAM_START === 1'b1) begin
            if (notes.size() == 0) check({1'b1, PROGRAM_BUFFER, 9'h000, PROGRAM_PAGE}, 23'h0);
            else check({1'b1, PROGRAM_BUFFER, 9'h000, PROGRAM_PAGE}, notes.pop_front());
        end
    end
    // watchdog
    initial begin
        #400000;
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0t: watchdog expired", $time);
        close_out;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge CLK);
        @(negedge CLK) RESET_N = 1'b1;
        @(posedge CLK);
        #1;
        check({ERASE_FILL, BUSY, ERASE_START, PROGRAM_START, PROGRAM_BUFFER}, {8'hFF, 4'h0});
        for (m = 0; m < 2; m = m + 1) begin
            @(negedge CLK) PAGE_MODE_256 = m[0];
            for (i = 0; i < 10; i = i + 1) begin
                op = optab[79 - 8 * i -: 8];
                seed = xs(seed);
                if (op == 8'h81) pg = seed[11:0];
                else if (op != 8'h88 && op != 8'h89) pg = seed[23:12];
                if (i == 7 && pg[11:8] == 4'h0) pg[11] = 1'b1;
                if (i == 8) pg = {9'h000, seed[2:0]};
                if (i == 9) pg = {4'h0, seed[7:4], 1'b1, seed[2:0]};
                run(op, pg);
            end
        end
        // frame during a long erase, a short frame and an unknown opcode are dropped
        expect_op(8'h7C, 12'hA37);
        send(8'h7C, 12'hA37, 6'h20);
        wait_busy(1'b1, 20);
        send(8'h81, 12'h123, 6'h20);
        wait_busy(1'b0, 3000);
        send(8'h84, 12'h456, 6'h20);
        // 31 bits after a zero: a receiver ignoring the bit count would see a block erase
        send(8'hA0, 12'h456, 6'h1F);
        repeat (40) @(posedge CLK);
        check({22'h0, BUSY}, 23'h0);
        check({22'h0, notes.size() != 0}, 23'h0);
        close_out;
    end
endmodule
